// *** inc/swce_pkg.sv ***
// constants, command layout and state record of the single-wire command executor
// assumes one 25 MHz core clock and a 32-bit classic Wishbone register port

package swce_pkg;

	////////////////////////////////////////////////////////////////////////////
	// clock and timebase
	localparam int CLK_HZ      = 25_000_000;
	localparam int HZ_PER_MHZ  = 1_000_000;
	localparam int US_CYC      = CLK_HZ / HZ_PER_MHZ;
	localparam int OD_TICK_CYC = 3;
	localparam int PRE_W       = 5;

	typedef logic [16:0] swce_tmr_t;
	typedef logic [31:0] swce_word_t;
	typedef logic [7:0]  swce_byte_t;
	typedef logic [7:0]  swce_adr_t;

	// wire timing in microsecond ticks, overdrive ticks are shorter
	localparam swce_tmr_t T_RST_LOW  = swce_tmr_t'(480);
	localparam swce_tmr_t T_SHORT    = swce_tmr_t'(2);
	localparam swce_tmr_t T_PRES     = swce_tmr_t'(70);
	localparam swce_tmr_t T_RST_END  = swce_tmr_t'(480);
	localparam swce_tmr_t T_LOW1     = swce_tmr_t'(6);
	localparam swce_tmr_t T_LOW0     = swce_tmr_t'(60);
	localparam swce_tmr_t T_SAMPLE   = swce_tmr_t'(15);
	localparam swce_tmr_t T_SLOT     = swce_tmr_t'(70);
	localparam swce_tmr_t T_DUR_UNIT = swce_tmr_t'(512);

	////////////////////////////////////////////////////////////////////////////
	// register map, byte addresses
	localparam swce_adr_t A_CMD      = 8'h00;
	localparam swce_adr_t A_CTRL     = 8'h04;
	localparam swce_adr_t A_STATUS   = 8'h08;
	localparam swce_adr_t A_RESULT   = 8'h0C;
	localparam swce_adr_t A_RDATA    = 8'h10;
	localparam swce_adr_t A_PP_DUR   = 8'h14;
	localparam swce_adr_t A_SPU_DUR  = 8'h18;
	localparam swce_adr_t A_IRQ_STAT = 8'h1C;
	localparam swce_adr_t A_IRQ_MASK = 8'h20;

	localparam int CTL_HALT_IDLE = 0;
	localparam int CTL_HALT_DONE = 1;
	localparam int CTL_RESUME    = 2;

	localparam int STB_BUSY   = 0;
	localparam int STB_HALTED = 1;
	localparam int STB_PROGV  = 2;
	localparam int STB_RESV   = 3;
	localparam int STB_DATAV  = 4;
	localparam int STB_PEND   = 5;
	localparam int STB_SPD    = 6;

	localparam int IRQ_DONE = 0;
	localparam int IRQ_RES  = 1;
	localparam int IRQ_DATA = 2;
	localparam int IRQ_W    = 3;

	////////////////////////////////////////////////////////////////////////////
	// codes and reset values
	localparam swce_byte_t RES_OK     = 8'h00;
	localparam swce_byte_t RES_SHORT  = 8'h01;
	localparam swce_byte_t RES_NOPRES = 8'h02;
	localparam swce_byte_t RES_ALARM  = 8'h04;
	localparam swce_byte_t RES_VPP    = 8'h08;
	localparam swce_byte_t DUR_INF    = 8'hFF;
	localparam swce_byte_t DUR_RST    = 8'h01;

	typedef enum logic [1:0] {
		OP_SET_DUR = 2'b00,
		OP_PULSE   = 2'b01,
		OP_RESET   = 2'b10,
		OP_BIT_IO  = 2'b11
	} swce_op_e;

	typedef enum logic [1:0] {
		SPD_REGULAR = 2'b00,
		SPD_FLEX    = 2'b01,
		SPD_OD      = 2'b10
	} swce_spd_e;

	localparam swce_byte_t PAR_REGULAR = 8'h00;
	localparam swce_byte_t PAR_FLEX    = 8'h01;
	localparam swce_byte_t PAR_OD      = 8'h02;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_PULSE   = 3'b001,
		ST_RST_LOW = 3'b010,
		ST_RST_WT  = 3'b011,
		ST_SLOT    = 3'b100,
		ST_FINISH  = 3'b101
	} swce_fsm_e;

	// command word as written to A_CMD; sel picks strong pullup / speed change / pullup
	typedef struct packed {
		logic [7:0] rsv_hi;
		swce_byte_t param;
		logic [5:0] rsv_mid;
		swce_op_e   op;
		logic [2:0] rsv_lo;
		logic       pullup_if_zero_only;
		logic       bit_value;
		logic       sel;
		logic       notify_success_flag;
		logic       suppress_result_flag;
	} swce_cmd_s;

	typedef struct packed {
		swce_fsm_e        fsm;
		logic [PRE_W-1:0] pre;
		swce_tmr_t        tmr;
		swce_cmd_s        cmd;
		logic             pend;
		logic             halted;
		logic             pkind;
		swce_byte_t       pp_dur;
		swce_byte_t       spu_dur;
		swce_spd_e        speed;
		logic             progv;
		logic             sampled;
		logic             smp_a;
		logic             smp_b;
		swce_byte_t       err;
		swce_byte_t       result;
		logic             res_v;
		swce_byte_t       rdata;
		logic             data_v;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic             irq;
		logic             ow_oe;
		logic             prog_en;
		logic             spu_en;
		logic             ack;
		swce_word_t       dat;
	} swce_st_s;

endpackage

// *** design/swce_top.sv ***
// single-wire command executor: set duration, pulse, bus reset, bit slot
// assumes a classic Wishbone master on CORE_CLK and an external open-drain
// driver plus +12V / strong pullup switches on the wire
//
// How it works
// RULE1: set-duration loads byte into selected register
// RULE2: stored duration persists until next overwrite
// RULE3: infinite pulse ends on halt; resume restarts
// RULE4: set-duration result 0x00 only if notified
// RULE5: pulse drives programming level or strong pullup
// RULE6: pulse length from matching duration register
// RULE7: programming voltage flag sits in status bit2
// RULE8: pulse records missing voltage, 0x00 if notified
// RULE9: bus reset, then speed change when enabled
// RULE10: speed byte 0 regular, 1 flexible, 2 overdrive
// RULE11: host follows overdrive skip with reset 0x02
// RULE12: reset records fault flags, 0x00 if notified
// RULE13: bit command makes one slot, writes d3, samples
// RULE14: optional strong pullup after slot, conditional on zero
// RULE15: sampled bit returned unless result suppressed
// RULE16: bit command result 0x00 only if notified
// RULE17: returned byte holds bit in bit0, rest zero
// RULE18: commands run singly, each finished before next
`timescale 1ns/1ps

module swce_top
	import swce_pkg::*;
#(
	parameter int TICK_CYC = US_CYC,
	parameter int OD_CYC   = OD_TICK_CYC
) (
	// clock and reset
	input  wire logic              CORE_CLK,
	input  wire logic              RST_N,
	// wishbone slave
	input  wire logic              WB_CYC_I,
	input  wire logic              WB_STB_I,
	input  wire logic              WB_WE_I,
	input  wire swce_pkg::swce_adr_t  WB_ADR_I,
	input  wire logic [3:0]        WB_SEL_I,
	input  wire swce_pkg::swce_word_t WB_DAT_I,
	output swce_pkg::swce_word_t       WB_DAT_O,
	output logic                   WB_ACK_O,
	output logic                   IRQ,
	// single-wire bus, open drain
	input  wire logic              OW_IN,
	output logic                   OW_OUT,
	output logic                   OW_OE,
	// pulse switches and supply sense
	output logic                   PROG_PULSE_EN,
	output logic                   STRONG_PULLUP_EN,
	input  wire logic              PROG_VOLT_IN
);
	import swce_pkg::*;

	if (TICK_CYC < 1 || TICK_CYC > 2**PRE_W || OD_CYC < 1 || OD_CYC > 2**PRE_W) begin : g_chk
		$error("swce_top: tick divisor out of range");
	end

	////////////////////////////////////////////////////////////////////////////
	swce_st_s s_reg;
	swce_st_s s_next;

	always_comb begin
		logic       wr;
		logic       rd;
		logic       tick;
		logic       fin;
		swce_byte_t dur;
		swce_tmr_t  lim;
		swce_tmr_t  low;
		logic [IRQ_W-1:0] ev;
		wr   = 1'b0;
		rd   = 1'b0;
		tick = 1'b0;
		fin  = 1'b0;
		dur  = '0;
		lim  = '0;
		low  = '0;
		ev   = '0;
		s_next = s_reg;
		s_next.progv = PROG_VOLT_IN;
		wr = WB_CYC_I & WB_STB_I & WB_WE_I & ~s_reg.ack;
		rd = WB_CYC_I & WB_STB_I & ~WB_WE_I & ~s_reg.ack;

		// timebase; pulses always count in regular microseconds
		tick = (s_reg.pre == '0);
		if (tick) begin
			if (s_reg.speed == SPD_OD && s_reg.fsm != ST_PULSE) begin
				s_next.pre = PRE_W'(OD_CYC - 1);
			end else begin
				s_next.pre = PRE_W'(TICK_CYC - 1);
			end
			s_next.tmr = swce_tmr_t'(s_reg.tmr + 1'b1);
		end else begin
			s_next.pre = PRE_W'(s_reg.pre - 1'b1);
		end

		////////////////////////////////////////////////////////////////////////
		// bus side effects first so hardware sets below win over clears
		if (wr) begin
			unique case (WB_ADR_I)
				A_CMD: begin
					// one command at a time; the running one still reads this copy
					if (!s_reg.pend && s_reg.fsm == ST_IDLE) begin //RULE18
						if (WB_SEL_I[2:0] == 3'b111) begin
							s_next.cmd  = swce_cmd_s'(WB_DAT_I);
							s_next.pend = 1'b1;
						end
					end
				end
				A_CTRL: begin
					if (WB_SEL_I[0]) begin
						if (WB_DAT_I[CTL_HALT_IDLE] || WB_DAT_I[CTL_HALT_DONE]) begin
							s_next.halted = 1'b1;
						end else if (WB_DAT_I[CTL_RESUME]) begin
							s_next.halted = 1'b0; //RULE3
						end
					end
				end
				A_PP_DUR: begin
					if (WB_SEL_I[0]) begin
						s_next.pp_dur = WB_DAT_I[7:0]; //RULE2
					end
				end
				A_SPU_DUR: begin
					if (WB_SEL_I[0]) begin
						s_next.spu_dur = WB_DAT_I[7:0]; //RULE2
					end
				end
				A_IRQ_STAT: begin
					if (WB_SEL_I[0]) begin
						s_next.irq_stat = s_reg.irq_stat & ~WB_DAT_I[IRQ_W-1:0];
					end
				end
				A_IRQ_MASK: begin
					if (WB_SEL_I[0]) begin
						s_next.irq_mask = WB_DAT_I[IRQ_W-1:0];
					end
				end
				default: begin
				end
			endcase
		end
		if (rd && WB_ADR_I == A_RESULT) begin
			s_next.res_v = 1'b0;
		end
		if (rd && WB_ADR_I == A_RDATA) begin
			s_next.data_v = 1'b0;
		end

		////////////////////////////////////////////////////////////////////////
		unique case (s_reg.fsm)
			ST_IDLE: begin
				if (s_reg.pend && !s_reg.halted) begin //RULE18
					s_next.pend    = 1'b0;
					s_next.err     = RES_OK;
					s_next.tmr     = '0;
					s_next.sampled = 1'b0;
					// restart the timebase so the first tick is a whole one
					if (s_reg.speed == SPD_OD && s_reg.cmd.op != OP_PULSE) begin
						s_next.pre = PRE_W'(OD_CYC - 1);
					end else begin
						s_next.pre = PRE_W'(TICK_CYC - 1);
					end
					unique case (s_reg.cmd.op)
						OP_SET_DUR: begin
							if (s_reg.cmd.sel) begin
								s_next.spu_dur = s_reg.cmd.param; //RULE1
							end else begin
								s_next.pp_dur = s_reg.cmd.param; //RULE1
							end
							s_next.fsm = ST_FINISH;
						end
						OP_PULSE: begin
							if (!s_reg.cmd.sel && !s_reg.progv) begin
								s_next.err = RES_VPP; //RULE8
								s_next.fsm = ST_FINISH;
							end else begin
								s_next.pkind   = s_reg.cmd.sel;
								s_next.prog_en = ~s_reg.cmd.sel; //RULE5
								s_next.spu_en  = s_reg.cmd.sel; //RULE5
								s_next.fsm     = ST_PULSE;
							end
						end
						OP_RESET: begin
							s_next.ow_oe = 1'b1;
							s_next.fsm   = ST_RST_LOW;
						end
						OP_BIT_IO: begin
							s_next.ow_oe = 1'b1; //RULE13
							s_next.fsm   = ST_SLOT;
						end
					endcase
				end
			end
			ST_PULSE: begin
				dur = s_reg.pkind ? s_reg.spu_dur : s_reg.pp_dur; //RULE6
				lim = swce_tmr_t'(swce_tmr_t'(dur) * T_DUR_UNIT);
				if (dur == DUR_INF) begin
					fin = s_reg.halted; //RULE3
				end else begin
					// ends on the tick that completes the last unit, not one later
					fin = tick && (swce_tmr_t'(s_reg.tmr + 1'b1) >= lim);
				end
				if (fin) begin
					s_next.prog_en = 1'b0;
					s_next.spu_en  = 1'b0;
					s_next.fsm     = ST_FINISH;
				end
			end
			ST_RST_LOW: begin
				if (s_reg.tmr >= T_RST_LOW) begin
					s_next.ow_oe = 1'b0;
					s_next.tmr   = '0;
					s_next.fsm   = ST_RST_WT;
				end
			end
			ST_RST_WT: begin
				if (s_reg.tmr == T_SHORT) begin
					s_next.smp_a = OW_IN;
				end
				if (s_reg.tmr == T_PRES) begin
					s_next.smp_b = OW_IN;
				end
				if (s_reg.tmr >= T_RST_END) begin
					// low straight after release: short if it stays low, else early presence
					if (!s_reg.smp_a && !OW_IN) begin
						s_next.err = RES_SHORT; //RULE12
					end else if (!s_reg.smp_a) begin
						s_next.err = RES_ALARM; //RULE12
					end else if (s_reg.smp_b) begin
						s_next.err = RES_NOPRES; //RULE12
					end
					if (s_reg.cmd.sel) begin //RULE9
						if (s_reg.cmd.param == PAR_REGULAR) begin
							s_next.speed = SPD_REGULAR; //RULE10
						end else if (s_reg.cmd.param == PAR_FLEX) begin
							s_next.speed = SPD_FLEX; //RULE10
						end else if (s_reg.cmd.param == PAR_OD) begin
							s_next.speed = SPD_OD; //RULE10 RULE11
						end
					end
					s_next.fsm = ST_FINISH;
				end
			end
			ST_SLOT: begin
				low          = s_reg.cmd.bit_value ? T_LOW1 : T_LOW0;
				s_next.ow_oe = (s_reg.tmr < low); //RULE13
				if (s_reg.tmr == T_SAMPLE) begin
					s_next.sampled = OW_IN; //RULE13
				end
				if (s_reg.tmr >= T_SLOT) begin
					s_next.ow_oe = 1'b0;
					if (s_reg.cmd.sel && (!s_reg.cmd.pullup_if_zero_only || !s_reg.sampled)) begin
						s_next.pkind  = 1'b1; //RULE14
						s_next.spu_en = 1'b1; //RULE14
						s_next.tmr    = '0;
						s_next.pre    = PRE_W'(TICK_CYC - 1);
						s_next.fsm    = ST_PULSE;
					end else begin
						s_next.fsm = ST_FINISH;
					end
				end
			end
			ST_FINISH: begin
				if (!s_reg.cmd.suppress_result_flag) begin
					if (s_reg.cmd.op == OP_BIT_IO) begin
						s_next.rdata  = {7'b000_0000, s_reg.sampled}; //RULE15 RULE17
						s_next.data_v = 1'b1; //RULE15
						ev[IRQ_DATA]  = 1'b1;
					end
					if (s_reg.err != RES_OK) begin
						s_next.result = s_reg.err; //RULE8 RULE12
						s_next.res_v  = 1'b1;
						ev[IRQ_RES]   = 1'b1;
					end else if (s_reg.cmd.notify_success_flag) begin
						s_next.result = RES_OK; //RULE4 RULE16
						s_next.res_v  = 1'b1;
						ev[IRQ_RES]   = 1'b1;
					end
				end
				ev[IRQ_DONE] = 1'b1;
				s_next.fsm   = ST_IDLE; //RULE18
			end
			default: begin
				s_next.fsm = ST_IDLE;
			end
		endcase

		////////////////////////////////////////////////////////////////////////
		s_next.irq_stat = s_next.irq_stat | ev;
		s_next.irq      = |(s_next.irq_stat & s_next.irq_mask);
		s_next.ack      = WB_CYC_I & WB_STB_I & ~s_reg.ack;
		s_next.dat      = '0;
		if (rd) begin
			unique case (WB_ADR_I)
				A_CMD:      s_next.dat = swce_word_t'(s_reg.cmd);
				A_STATUS: begin
					s_next.dat[STB_BUSY]      = (s_reg.fsm != ST_IDLE);
					s_next.dat[STB_HALTED]    = s_reg.halted;
					s_next.dat[STB_PROGV]     = s_reg.progv; //RULE7
					s_next.dat[STB_RESV]      = s_reg.res_v;
					s_next.dat[STB_DATAV]     = s_reg.data_v;
					s_next.dat[STB_PEND]      = s_reg.pend;
					s_next.dat[STB_SPD +: 2]  = s_reg.speed;
				end
				A_RESULT:   s_next.dat[7:0] = s_reg.result;
				A_RDATA:    s_next.dat[7:0] = s_reg.rdata;
				A_PP_DUR:   s_next.dat[7:0] = s_reg.pp_dur;
				A_SPU_DUR:  s_next.dat[7:0] = s_reg.spu_dur;
				A_IRQ_STAT: s_next.dat[IRQ_W-1:0] = s_reg.irq_stat;
				A_IRQ_MASK: s_next.dat[IRQ_W-1:0] = s_reg.irq_mask;
				default:    s_next.dat = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			s_reg         <= '0;
			s_reg.fsm     <= ST_IDLE;
			s_reg.pp_dur  <= DUR_RST;
			s_reg.spu_dur <= DUR_RST;
			s_reg.speed   <= SPD_REGULAR;
		end else begin
			s_reg <= s_next;
		end
	end

	assign WB_DAT_O         = s_reg.dat;
	assign WB_ACK_O         = s_reg.ack;
	assign IRQ              = s_reg.irq;
	assign OW_OUT           = 1'b0;
	assign OW_OE            = s_reg.ow_oe;
	assign PROG_PULSE_EN    = s_reg.prog_en;
	assign STRONG_PULLUP_EN = s_reg.spu_en;

endmodule

// *** tb/swce_top_properties.sv ***
// pin-level assertions for swce_top
// bound to every instance; sees top ports only
`timescale 1ns/1ps
module swce_top_properties
	import swce_pkg::*;
#(
	parameter int TICK_CYC = 1,
	parameter int OD_CYC   = 1
) (
	// clock and reset
	input wire logic       CORE_CLK,
	input wire logic       RST_N,
	// register bus
	input wire logic       WB_CYC_I,
	input wire logic       WB_STB_I,
	input wire logic       WB_ACK_O,
	input wire swce_word_t WB_DAT_O,
	// wire, pulse switches and supply sense
	input wire logic       OW_OUT,
	input wire logic       OW_OE,
	input wire logic       PROG_PULSE_EN,
	input wire logic       STRONG_PULLUP_EN,
	input wire logic       PROG_VOLT_IN
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	////////////////////////////////////////
	a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |-> ##[1:2] WB_ACK_O)
		else $error("request not acknowledged");
	a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held too long");
	a_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == '0)
		else $error("read data outside ack");
	a_wire_od: assert property (OW_OUT == 1'b0)
		else $error("wire data driven high");
	a_pulse_excl: assert property (!(PROG_PULSE_EN && STRONG_PULLUP_EN))
		else $error("both pulse kinds on");
	a_pulse_quiet: assert property (PROG_PULSE_EN || STRONG_PULLUP_EN |-> !OW_OE)
		else $error("wire pulled low during pulse");
	a_prog_volt: assert property ($rose(PROG_PULSE_EN) |-> $past(PROG_VOLT_IN, 2))
		else $error("programming pulse without supply");
	a_slot_min: assert property ($rose(OW_OE) |=> OW_OE[*3])
		else $error("low phase too short");
	a_spu_len: assert property ($rose(STRONG_PULLUP_EN) |=> STRONG_PULLUP_EN[*8])
		else $error("strong pullup too short");
	a_prog_len: assert property ($rose(PROG_PULSE_EN) |=> PROG_PULSE_EN[*8])
		else $error("programming pulse too short");
endmodule

bind swce_top swce_top_properties #(.TICK_CYC(TICK_CYC), .OD_CYC(OD_CYC)) u_props (
	.CORE_CLK(CORE_CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
	.WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O), .OW_OUT(OW_OUT), .OW_OE(OW_OE),
	.PROG_PULSE_EN(PROG_PULSE_EN), .STRONG_PULLUP_EN(STRONG_PULLUP_EN),
	.PROG_VOLT_IN(PROG_VOLT_IN)
);

// *** tb/swce_wire_slave.sv ***
// slave on the single-wire bus: presence after reset, read bit per slot
// wire has a pull-up, so it is low while either side pulls
`timescale 1ns/1ps
module swce_wire_slave (
	// clock and wire
	input wire logic CORE_CLK,
	input wire logic OW_OE,
	// behaviour of the slave
	input wire logic PRESENT,
	input wire logic RESP_BIT,
	input wire logic SHORT,
	input wire logic ALARM,
	// resolved wire level
	output logic     OW_IN
);
	logic [9:0] low_cnt = 10'h000;
	logic [7:0] pres_cnt = 8'h00;
	logic [7:0] slot_cnt = 8'h00;
	logic       oe_q = 1'b0;
	always @(posedge CORE_CLK) begin
		oe_q <= OW_OE;
		low_cnt <= OW_OE ? low_cnt + {9'h000, low_cnt != 10'h3FF} : 10'h000;
		if (pres_cnt != 8'h00)
			pres_cnt <= pres_cnt - 8'h01;
		if (slot_cnt != 8'h00)
			slot_cnt <= slot_cnt - 8'h01;
		// long low phase only counts as a reset
		if (oe_q && !OW_OE && low_cnt > 10'h190 && PRESENT)
			pres_cnt <= 8'h96;
		if (!oe_q && OW_OE && !RESP_BIT)
			slot_cnt <= 8'h1E;
	end
	// alarm presence pulls low straight after release, a short holds the wire low
	assign OW_IN = !(OW_OE || SHORT || slot_cnt != 8'h00 ||
		(pres_cnt != 8'h00 && (pres_cnt < 8'h8C || ALARM)));
endmodule

// *** tb/tb.sv ***
// self-checking bench for swce_top with a wire slave model
// one clock; one cycle per tick to keep pulses short
`timescale 1ns/1ps
module tb;
	import swce_pkg::*;
	logic       clk, rst_n, cyc, stb, we, volt, pres, resp, shorted, alarm;
	logic       ack, irq, ow_out, ow_oe, ow_in, pp_en, spu_en;
	logic [3:0] sel;
	swce_adr_t  adr;
	swce_word_t wdat, rdat, rd;
	int         err_total, compares, cycles, oe_rises, pp_cnt, spu_cnt, n0;

	swce_top #(.TICK_CYC(1), .OD_CYC(1)) uut (.CORE_CLK(clk), .RST_N(rst_n),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
		.WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .IRQ(irq), .OW_IN(ow_in),
		.OW_OUT(ow_out), .OW_OE(ow_oe), .PROG_PULSE_EN(pp_en),
		.STRONG_PULLUP_EN(spu_en), .PROG_VOLT_IN(volt));
	swce_wire_slave u_slave (.CORE_CLK(clk), .OW_OE(ow_oe), .PRESENT(pres),
		.RESP_BIT(resp), .SHORT(shorted), .ALARM(alarm), .OW_IN(ow_in));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if ($rose(ow_oe))
			oe_rises <= oe_rises + 1;
		pp_cnt <= pp_cnt + int'(pp_en);
		spu_cnt <= spu_cnt + int'(spu_en);
		if (cycles == 40000) begin
			err_total++;
			complete_run;
		end
	end
	////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// holds the request until ack is sampled, then one idle cycle
	task automatic wb(input logic w, input swce_adr_t a, input swce_word_t d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) begin
			err_total++;
			$display("[FAIL] wb_ack expected 1 seen %b", ack);
		end
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic run(input swce_op_e op, input swce_byte_t p, input logic [4:0] f);
		int n;
		n = 0;
		wb(1'b1, A_CMD, {8'h00, p, 6'h00, op, 3'h0, f});
		do begin
			wb(1'b0, A_STATUS, '0);
			n++;
		end while ((rd[5] || rd[0]) && n < 3000);
		if (rd[5] || rd[0]) begin
			err_total++;
			$display("[FAIL] run_idle expected 0 seen %b", {rd[5], rd[0]});
		end
	endtask
	task automatic rdchk(input string nm, input swce_adr_t a, input logic [31:0] exp);
		wb(1'b0, a, '0);
		chk(nm, exp, {24'h00_0000, rd[7:0]});
	endtask
	////////////////////////////////////////
	task automatic t_dur;
		rdchk("pp_rst", A_PP_DUR, DUR_RST);
		rdchk("unmapped", 8'h40, 0);
		run(OP_SET_DUR, 8'h03, 5'h02);
		rdchk("pp_new", A_PP_DUR, 8'h03);
		rdchk("spu_kept", A_SPU_DUR, DUR_RST);
		rdchk("res_valid", A_STATUS, 8'h0C);
		rdchk("res_ok", A_RESULT, RES_OK);
		run(OP_SET_DUR, 8'h01, 5'h07);
		rdchk("spu_set", A_SPU_DUR, 8'h01);
		rdchk("res_none", A_STATUS, 8'h04);
		$display("set duration done");
	endtask
	task automatic t_pulse;
		volt <= 1'b0;
		repeat (3) @(posedge clk);
		run(OP_PULSE, 8'h00, 5'h00);
		rdchk("no_volt", A_STATUS, 8'h08);
		rdchk("vpp_code", A_RESULT, RES_VPP);
		chk("no_pulse", 0, pp_cnt);
		volt <= 1'b1;
		repeat (3) @(posedge clk);
		rdchk("volt_flag", A_STATUS, 8'h04);
		run(OP_PULSE, 8'h00, 5'h02);
		chk("pp_len", 3 * T_DUR_UNIT, pp_cnt);
		chk("spu_idle", 0, spu_cnt);
		run(OP_PULSE, 8'h00, 5'h04);
		chk("spu_len", T_DUR_UNIT, spu_cnt);
		$display("pulse done");
	endtask
	task automatic t_halt;
		run(OP_SET_DUR, DUR_INF, 5'h04);
		wb(1'b1, A_CMD, {22'h00_0000, OP_PULSE, 8'h04});
		repeat (2000) @(posedge clk);
		chk("inf_on", 1, spu_en);
		wb(1'b1, A_CTRL, 32'h0000_0001);
		repeat (4) @(posedge clk);
		chk("inf_off", 0, spu_en);
		wb(1'b1, A_CMD, {16'h0001, 6'h00, OP_SET_DUR, 8'h04});
		repeat (20) @(posedge clk);
		wb(1'b0, A_STATUS, '0);
		chk("held", 2'b11, {rd[5], rd[1]});
		wb(1'b1, A_CTRL, 32'h0000_0004);
		run(OP_SET_DUR, 8'h01, 5'h04);
		rdchk("spu_back", A_SPU_DUR, 8'h01);
		$display("halt done");
	endtask
	task automatic t_reset;
		wb(1'b0, A_RESULT, '0);
		for (int s = 2; s >= 0; s--) begin
			run(OP_RESET, s[7:0], 5'h06);
			wb(1'b0, A_STATUS, '0);
			chk("speed", s, rd[7:6]);
			rdchk("rst_ok", A_RESULT, RES_OK);
		end
		run(OP_RESET, PAR_OD, 5'h02);
		rdchk("speed_kept", A_STATUS, 8'h0C);
		pres <= 1'b0;
		run(OP_RESET, 8'h00, 5'h00);
		rdchk("no_pres", A_RESULT, RES_NOPRES);
		pres <= 1'b1;
		shorted <= 1'b1;
		run(OP_RESET, 8'h00, 5'h00);
		rdchk("short", A_RESULT, RES_SHORT);
		shorted <= 1'b0;
		alarm <= 1'b1;
		run(OP_RESET, 8'h00, 5'h00);
		rdchk("alarm", A_RESULT, RES_ALARM);
		alarm <= 1'b0;
		$display("bus reset done");
	endtask
	task automatic t_bit;
		for (int i = 0; i < 3; i++) begin
			resp <= i != 1;
			n0 = oe_rises;
			run(OP_BIT_IO, 8'h00, {1'b0, i != 2, 3'b010});
			chk("one_slot", 1, oe_rises - n0);
			rdchk("bit_back", A_RDATA, i == 0);
			rdchk("bit_res", A_RESULT, RES_OK);
		end
		run(OP_BIT_IO, 8'h00, 5'h0B);
		rdchk("no_data", A_STATUS, 8'h04);
		for (int i = 0; i < 3; i++) begin
			resp <= i != 1;
			n0 = spu_cnt;
			run(OP_BIT_IO, 8'h00, {i != 2, 4'hD});
			chk("pullup", i != 0, spu_cnt != n0);
		end
		$display("bit io done");
	endtask
	task automatic t_irq;
		wb(1'b1, A_IRQ_STAT, 32'h0000_0007);
		wb(1'b1, A_IRQ_MASK, 32'h0000_0001);
		chk("irq_clear", 0, irq);
		run(OP_SET_DUR, 8'h01, 5'h04);
		chk("irq_set", 1, irq);
		wb(1'b1, A_IRQ_STAT, 32'h0000_0001);
		chk("irq_w1c", 0, irq);
		wb(1'b1, A_IRQ_MASK, 32'h0000_0000);
		run(OP_SET_DUR, 8'h01, 5'h04);
		chk("irq_masked", 0, irq);
		rdchk("irq_stat", A_IRQ_STAT, 8'h01);
		$display("interrupt done");
	endtask
	task automatic complete_run;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		{rst_n, cyc, stb, we, shorted, alarm} = '0;
		{volt, pres, resp} = 3'h7;
		{adr, wdat} = '0;
		sel = 4'hF;
		{err_total, compares, cycles, oe_rises, pp_cnt, spu_cnt} = '0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_dur;
		t_pulse;
		t_halt;
		t_reset;
		t_bit;
		t_irq;
		complete_run;
	end
endmodule
